// >>> bench/sdpd_ctrl_props.sv
// Checker on the power-down controller ports
`timescale 1ns/1ns
`default_nettype none
module sdpd_ctrl_props
   import sdpd_pkg::*;
(
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      reset_n,
   input  wire logic                      clock_enable,
   input  wire sdpd_pkg::sdpd_cmd_type    cmd,
   input  wire sdpd_pkg::sdpd_status_type status,
   input  wire logic [7:0]                bank_open
);
   logic pd;
   logic run;
   logic idle_cmd;
   assign pd = status.active_pd | status.precharge_pd;
   assign run = reset_n & ~status.in_reset & ~pd;
   assign idle_cmd = (cmd == SDPD_CMD_NOP) | (cmd == SDPD_CMD_DESELECT);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence entry_req;
      run && !clock_enable && idle_cmd;
   endsequence
   // Buffers stay on for the one settling cycle, then drop
   sequence settle_seq;
      status.buffers_on ##1 !status.buffers_on;
   endsequence
   // Bank flags lag one cycle, so a fresh activate or precharge is skipped
   a_entry_precharge: assert property (
      entry_req ##0 (bank_open == 8'h00 && $past(cmd) != SDPD_CMD_ACTIVATE)
      |=> status.precharge_pd && !status.active_pd) else $error("no precharge entry");
   a_entry_active: assert property (
      entry_req ##0 (bank_open != 8'h00 && !($past(cmd) inside {SDPD_CMD_PRECHARGE,
      SDPD_CMD_PREALL})) |=> status.active_pd && status.loop_on) else $error("no active entry");
   a_exit_on_enable: assert property (
      pd && clock_enable && reset_n |=> !pd && status.loop_on && status.buffers_on)
      else $error("no exit");
   a_pd_residency: assert property (
      pd && !clock_enable && reset_n |=> $stable(status.active_pd)
      && $stable(status.precharge_pd)) else $error("left power-down");
   a_settle_buffers: assert property (
      $rose(pd) && !clock_enable && reset_n |-> settle_seq) else $error("buffer settle");
   a_reset_pin: assert property (
      !reset_n |=> status.in_reset && !status.outputs_en && !status.term_en && !pd)
      else $error("reset pin ignored");
   a_reset_banks: assert property (
      !reset_n [*2] |=> bank_open == 8'h00) else $error("banks kept over reset");
   a_refused_entry: assert property (
      run && !clock_enable && (cmd inside {SDPD_CMD_READ, SDPD_CMD_WRITE, SDPD_CMD_MRS})
      |=> !pd) else $error("entry on busy command");
endmodule
bind sdpd_ctrl sdpd_ctrl_props u_props (.mclk(mclk), .rst(rst), .reset_n(reset_n),
   .clock_enable(clock_enable), .cmd(cmd), .status(status), .bank_open(bank_open));
`default_nettype wire

// >>> bench/sdpd_ctrl_test.sv
// Self-checking bench for the power-down and reset controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module sdpd_ctrl_test;
   import sdpd_pkg::*;
   logic            mclk = 1'h0;
   logic            rst = 1'h1;
   logic            reset_n;
   logic            clock_enable;
   logic            loop_locked;
   logic            refresh_keep;
   sdpd_cmd_type    cmd;
   logic [2:0]      cmd_bank;
   logic [2:0]      write_recovery_cycles;
   logic [15:0]     mode_reg_zero_data;
   logic [7:0]      bank_open;
   sdpd_status_type status;
   int              mismatches = 0;
   int              total_checks = 0;
   int              cycles = 0;
   always #50 mclk = ~mclk;
   sdpd_host_model ctl (.mclk(mclk), .reset_n(reset_n), .clock_enable(clock_enable),
      .cmd(cmd), .cmd_bank(cmd_bank), .mode_reg_zero_data(mode_reg_zero_data),
      .loop_locked(loop_locked));
   sdpd_ctrl DUT (.mclk(mclk), .rst(rst), .reset_n(reset_n), .clock_enable(clock_enable),
      .cmd(cmd), .cmd_bank(cmd_bank), .mode_reg_zero_data(mode_reg_zero_data),
      .loop_locked(loop_locked), .status(status),
      .write_recovery_cycles(write_recovery_cycles), .refresh_keep(refresh_keep),
      .bank_open(bank_open));
   task end_sim;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Whole run is some 60 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         mismatches++;
         end_sim();
      end
   end
   task mrs(input logic [15:0] d);
      ctl.step(SDPD_CMD_MRS, 1'h1, ~cmd_bank, d);
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
   endtask
   task t_reset;
      `CHK({status.in_reset, status.outputs_en, status.term_en, bank_open}, 11'h400)
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      `CHK(status.in_reset, 1'h0)
      mrs(16'h0e00);
      `CHK(write_recovery_cycles, 3'h7)
      mrs(16'h0200);
      `CHK(write_recovery_cycles, 3'h1)
      $display("reset and mode test done");
   endtask
   task t_pre_pd(input logic fast, input sdpd_cmd_type ent);
      mrs({3'h0, fast, 12'h000});
      ctl.issue(ent, 1'h0);
      ctl.no_operation_command(1'h0);
      `CHK({status.precharge_pd, status.active_pd, status.loop_on}, {2'h2, fast})
      `CHK(status.buffers_on, 1'h1)
      ctl.no_operation_command(1'h0);
      `CHK(status.buffers_on, 1'h0)
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      `CHK({status.precharge_pd, status.loop_on, status.buffers_on}, 3'h3)
      $display("precharge power-down test done");
   endtask
   task t_act_pd;
      ctl.open_bank(1'h1, 3'h3);
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      ctl.issue(SDPD_CMD_DESELECT, 1'h0);
      ctl.open_bank(1'h0, 3'h5);
      `CHK({status.active_pd, status.loop_on, bank_open}, 10'h308)
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      `CHK({status.active_pd, bank_open}, 9'h008)
      ctl.issue(SDPD_CMD_PREALL, 1'h1);
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      `CHK(bank_open, 8'h00)
      $display("active power-down test done");
   endtask
   task t_refuse;
      sdpd_cmd_type bad [3];
      bad = '{SDPD_CMD_READ, SDPD_CMD_WRITE, SDPD_CMD_MRS};
      foreach (bad[i])
      begin
         ctl.issue(bad[i], 1'h0);
         ctl.no_operation_command(1'h1);
         `CHK({status.active_pd, status.precharge_pd}, 2'h0)
      end
      $display("refused entry test done");
   endtask
   task t_reset_pd;
      ctl.lock(1'h0);
      ctl.open_bank(1'h1, 3'h0);
      ctl.no_operation_command(1'h0);
      ctl.no_operation_command(1'h0);
      `CHK({status.active_pd, refresh_keep}, 2'h3)
      ctl.pin_reset();
      `CHK({status.in_reset, status.active_pd, status.outputs_en, status.term_en}, 4'h8)
      `CHK(bank_open, 8'h00)
      ctl.lock(1'h1);
      ctl.no_operation_command(1'h1);
      ctl.no_operation_command(1'h1);
      `CHK(status.in_reset, 1'h0)
      $display("reset in power-down test done");
   endtask
   initial
   begin
      repeat (12) @(negedge mclk);
      rst = 1'h0;
      t_reset();
      t_pre_pd(1'h1, SDPD_CMD_DESELECT);
      t_pre_pd(1'h0, SDPD_CMD_NOP);
      t_act_pd();
      t_refuse();
      t_reset_pd();
      end_sim();
   end
endmodule
`default_nettype wire

// >>> bench/sdpd_host_model.sv
// Controller-side model driving command, clock enable and reset pins
`timescale 1ns/1ns
`default_nettype none
module sdpd_host_model
   import sdpd_pkg::*;
(
   input  wire logic                   mclk,
   output var  logic                   reset_n,
   output var  logic                   clock_enable,
   output var  sdpd_pkg::sdpd_cmd_type cmd,
   output var  logic [2:0]             cmd_bank,
   output var  logic [15:0]            mode_reg_zero_data,
   output var  logic                   loop_locked
);
   initial
   begin
      reset_n = 1'h1;
      clock_enable = 1'h0;
      cmd = SDPD_CMD_NOP;
      cmd_bank = 3'h0;
      mode_reg_zero_data = 16'h0000;
      loop_locked = 1'h1;
   end
   task step(input sdpd_cmd_type c, input logic cke, input logic [2:0] b, input logic [15:0] d);
      @(negedge mclk);
      cmd = c;
      clock_enable = cke;
      cmd_bank = b;
      mode_reg_zero_data = d;
   endtask
   // Unused lines toggle so no stale value can pass for a real one
   task no_operation_command(input logic cke);
      step(SDPD_CMD_NOP, cke, ~cmd_bank, ~mode_reg_zero_data);
   endtask
   // Bank and data lines toggle on commands that do not use them
   task issue(input sdpd_cmd_type c, input logic cke);
      step(c, cke, ~cmd_bank, ~mode_reg_zero_data);
   endtask
   task open_bank(input logic cke, input logic [2:0] b);
      step(SDPD_CMD_ACTIVATE, cke, b, ~mode_reg_zero_data);
   endtask
   task lock(input logic v);
      loop_locked = v;
   endtask
   // Two cycles low is 200 ns, above the floor
   task pin_reset;
      @(negedge mclk);
      clock_enable = 1'h0;
      reset_n = 1'h0;
      repeat (2) @(negedge mclk);
      reset_n = 1'h1;
   endtask
endmodule
`default_nettype wire

// >>> logic/sdpd_bank_track.sv
// One bank open flag, set by activate, cleared by precharge or reset
`timescale 1ns/1ns
`default_nettype none
module sdpd_bank_track
   import sdpd_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   rst,
   input  wire logic   open_hit,
   input  wire logic   close_hit,
   output var  logic   is_open
);
   import sdpd_pkg::*;

   logic next_is_open;

   always_comb
   begin
      next_is_open = is_open;
      if (close_hit)
      begin
         next_is_open = 1'b0;
      end
      else if (open_hit)
      begin
         next_is_open = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         is_open <= 1'b0;
      end
      else
      begin
         is_open <= next_is_open;
      end
   end
endmodule
`default_nettype wire

// >>> logic/sdpd_ctrl.sv
// Power-down entry, residency and exit plus reset handling of the memory device
`timescale 1ns/1ns
`default_nettype none
module sdpd_ctrl
   import sdpd_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             reset_n,
   input  wire logic             clock_enable,
   input  wire sdpd_pkg::sdpd_cmd_type cmd,
   input  wire logic [2:0]       cmd_bank,
   input  wire logic [15:0]      mode_reg_zero_data,
   input  wire logic             loop_locked,
   output var  sdpd_pkg::sdpd_status_type status,
   output var  logic [2:0]       write_recovery_cycles,
   output var  logic             refresh_keep,
   output var  logic [7:0]       bank_open
);
   import sdpd_pkg::*;

   sdpd_state_type  state;
   sdpd_state_type  next_state;
   logic [15:0]     mode_reg_zero;
   logic [15:0]     next_mode_reg_zero;
   logic [3:0]      settle_count;
   logic [3:0]      next_settle_count;
   logic            loop_on;
   logic            next_loop_on;
   logic            loop_unlocked_at_entry;
   logic            next_loop_unlocked_at_entry;
   sdpd_status_type next_status;
   logic            reset_seen;
   logic [7:0]      open_hits;
   logic [7:0]      close_hits;
   logic [7:0]      banks;
   logic            in_pd;
   logic            entry_cmd_ok;
   logic            cmd_open;
   logic            cmd_close_one;
   logic            cmd_close_all;
   logic            bank_cmd_ok;

   // Reset pin is caught every edge; reset acts ahead of any other event
   assign reset_seen = ~reset_n | rst;

   always_comb
   begin
      in_pd = 1'b0;
      case (state)
         SDPD_ST_ACT_PD, SDPD_ST_PRE_PD:
         begin
            in_pd = 1'b1;
         end
         default:
         begin
            in_pd = 1'b0;
         end
      endcase
   end

   // Only idle commands may carry an entry
   always_comb
   begin
      entry_cmd_ok = 1'b0;
      case (cmd)
         SDPD_CMD_NOP, SDPD_CMD_DESELECT:
         begin
            entry_cmd_ok = 1'b1;
         end
         default:
         begin
            entry_cmd_ok = 1'b0;
         end
      endcase
   end

   // Command classes for bank tracking
   always_comb
   begin
      cmd_open = 1'b0;
      cmd_close_one = 1'b0;
      cmd_close_all = 1'b0;
      case (cmd)
         SDPD_CMD_ACTIVATE:
         begin
            cmd_open = 1'b1;
         end
         SDPD_CMD_PRECHARGE, SDPD_CMD_READ_AP, SDPD_CMD_WRITE_AP:
         begin
            // Auto precharge closes its own bank at once; no recovery timing kept
            cmd_close_one = 1'b1;
         end
         SDPD_CMD_PREALL:
         begin
            cmd_close_all = 1'b1;
         end
         default:
         begin
            cmd_open = 1'b0;
         end
      endcase
   end

   // Bank commands only act while clock enable is high and out of power-down; reset clears banks regardless
   assign bank_cmd_ok = ~in_pd && clock_enable;

   always_comb
   begin
      open_hits = 8'h00;
      close_hits = 8'h00;
      for (int i = 0; i < SDPD_NUM_BANKS; i++)
      begin
         if (reset_seen)
         begin
            close_hits[i] = 1'b1;
         end
         else if (bank_cmd_ok && cmd_close_all)
         begin
            close_hits[i] = 1'b1;
         end
         else if (bank_cmd_ok && cmd_close_one && (cmd_bank == 3'(i)))
         begin
            close_hits[i] = 1'b1;
         end
         else if (bank_cmd_ok && cmd_open && (cmd_bank == 3'(i)))
         begin
            open_hits[i] = 1'b1;
         end
      end
   end

   genvar b;
   generate
      for (b = 0; b < SDPD_NUM_BANKS; b = b + 1)
      begin : g_bank
         sdpd_bank_track u_bank
         (
            .mclk      (mclk),
            .rst       (rst),
            .open_hit  (open_hits[b]),
            .close_hit (close_hits[b]),
            .is_open   (banks[b])
         );
      end
   endgenerate

   always_comb
   begin
      next_state = state;
      next_mode_reg_zero = mode_reg_zero;
      next_settle_count = settle_count;
      next_loop_on = loop_on;
      next_loop_unlocked_at_entry = loop_unlocked_at_entry;
      if (reset_seen)
      begin
         // Counters cleared; refresh counters live outside this block
         next_state = SDPD_ST_RESET;
         next_mode_reg_zero = SDPD_MR0_RESET;
         next_settle_count = 4'h0;
         next_loop_on = 1'b0;
         next_loop_unlocked_at_entry = 1'b0;
      end
      else
      begin
         if (!in_pd && clock_enable && cmd == SDPD_CMD_MRS)
         begin
            next_mode_reg_zero = mode_reg_zero_data;
         end
         if (settle_count != 4'h0)
         begin
            next_settle_count = settle_count - 4'h1;
         end
         case (state)
            SDPD_ST_RESET:
            begin
               // Leaving reset needs clock enable high, as after power-up
               if (clock_enable)
               begin
                  next_state = SDPD_ST_IDLE;
                  next_loop_on = 1'b1;
               end
            end
            SDPD_ST_IDLE, SDPD_ST_ACTIVE:
            begin
               if (!clock_enable && entry_cmd_ok)
               begin
                  next_settle_count = SDPD_ENTRY_SETTLE_CYCLES;
                  next_loop_unlocked_at_entry = ~loop_locked;
                  if (|banks)
                  begin
                     next_state = SDPD_ST_ACT_PD;
                     next_loop_on = 1'b1;
                  end
                  else
                  begin
                     next_state = SDPD_ST_PRE_PD;
                     next_loop_on = mode_reg_zero[SDPD_MR0_FAST_EXIT_BIT];
                  end
               end
               else if (|open_hits)
               begin
                  next_state = SDPD_ST_ACTIVE;
               end
               else if (~|(banks & ~close_hits))
               begin
                  next_state = SDPD_ST_IDLE;
               end
            end
            SDPD_ST_ACT_PD, SDPD_ST_PRE_PD:
            begin
               if (clock_enable)
               begin
                  // Same bank state as at entry; the loop relocks after slow exit
                  next_state = (|banks) ? SDPD_ST_ACTIVE : SDPD_ST_IDLE;
                  next_loop_on = 1'b1;
                  next_settle_count = 4'h0;
               end
            end
            default:
            begin
               next_state = SDPD_ST_RESET;
            end
         endcase
      end
   end

   always_comb
   begin
      next_status = '0;
      next_status.in_reset = (next_state == SDPD_ST_RESET);
      next_status.active_pd = (next_state == SDPD_ST_ACT_PD);
      next_status.precharge_pd = (next_state == SDPD_ST_PRE_PD);
      next_status.loop_on = next_loop_on;
      // Buffers drop once settling is over; outputs and termination off in reset
      next_status.buffers_on = !((next_state == SDPD_ST_ACT_PD
                                 || next_state == SDPD_ST_PRE_PD)
                                 && next_settle_count == 4'h0);
      next_status.outputs_en = (next_state != SDPD_ST_RESET);
      next_status.term_en = (next_state != SDPD_ST_RESET);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= SDPD_ST_RESET;
         mode_reg_zero <= SDPD_MR0_RESET;
         settle_count <= 4'h0;
         loop_on <= 1'b0;
         loop_unlocked_at_entry <= 1'b0;
         status <= '{default: 1'b0, in_reset: 1'b1};
         write_recovery_cycles <= 3'h0;
         refresh_keep <= 1'b0;
         bank_open <= SDPD_BANKS_RESET;
      end
      else
      begin
         state <= next_state;
         mode_reg_zero <= next_mode_reg_zero;
         settle_count <= next_settle_count;
         loop_on <= next_loop_on;
         loop_unlocked_at_entry <= next_loop_unlocked_at_entry;
         status <= next_status;
         write_recovery_cycles <= next_mode_reg_zero[SDPD_MR0_WR_MSB:SDPD_MR0_WR_LSB];
         refresh_keep <= ~reset_seen && next_loop_unlocked_at_entry;
         bank_open <= reset_seen ? SDPD_BANKS_RESET : banks;
      end
   end
endmodule
`default_nettype wire

// >>> logic/sdpd_pkg.sv
// Package for the power-down and reset controller of the memory device
package sdpd_pkg;

   // Command encodings seen on the decoded command input
   typedef enum logic [3:0]
   {
      SDPD_CMD_DESELECT  = 4'h0,
      SDPD_CMD_NOP       = 4'h1,
      SDPD_CMD_ACTIVATE  = 4'h2,
      SDPD_CMD_PRECHARGE = 4'h3,
      SDPD_CMD_PREALL    = 4'h4,
      SDPD_CMD_READ      = 4'h5,
      SDPD_CMD_READ_AP   = 4'h6,
      SDPD_CMD_WRITE     = 4'h7,
      SDPD_CMD_WRITE_AP  = 4'h8,
      SDPD_CMD_REFRESH   = 4'h9,
      SDPD_CMD_MRS       = 4'ha,
      SDPD_CMD_OTHER     = 4'hf
   } sdpd_cmd_type;

   typedef enum logic [2:0]
   {
      SDPD_ST_RESET     = 3'b000,
      SDPD_ST_IDLE      = 3'b001,
      SDPD_ST_ACTIVE    = 3'b010,
      SDPD_ST_ACT_PD    = 3'b011,
      SDPD_ST_PRE_PD    = 3'b100
   } sdpd_state_type;

   // Status carrier towards the core of the device
   typedef struct packed
   {
      logic       active_pd;
      logic       precharge_pd;
      logic       loop_on;
      logic       buffers_on;
      logic       outputs_en;
      logic       term_en;
      logic       in_reset;
   } sdpd_status_type;

   localparam int SDPD_NUM_BANKS          = 8;
   localparam int SDPD_MR0_FAST_EXIT_BIT  = 12;
   localparam int SDPD_MR0_WR_LSB         = 9;
   localparam int SDPD_MR0_WR_MSB         = 11;
   localparam logic [15:0] SDPD_MR0_RESET = 16'h0000;
   localparam logic [7:0]  SDPD_BANKS_RESET = 8'h00;

   // Entry settling delay in cycles after power-down entry
   localparam logic [3:0] SDPD_ENTRY_SETTLE_CYCLES = 4'h1;
   localparam int SDPD_CLOCK_NS = 100;

endpackage
